// [logic/mcodec_fifo.sv]
// Module: small valid/ready FIFO
`timescale 1ns/1ps
module mcodec_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wp_r;
  logic [AW:0]      rp_r;
  logic             wr;
  logic             rd;
  assign in_ready  = (wp_r - rp_r) != (AW+1)'(DEPTH);
  assign out_valid = wp_r != rp_r;
  assign out_data  = mem[rp_r[AW-1:0]];
  assign wr = in_valid && in_ready;
  assign rd = out_valid && out_ready;
  always_ff @(posedge sys_clk) begin
    if (wr) begin
      mem[wp_r[AW-1:0]] <= in_data;
    end
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (wr) begin
        wp_r <= wp_r + 1'b1;
      end
      if (rd) begin
        rp_r <= rp_r + 1'b1;
      end
    end
  end
endmodule

// [logic/mcodec_pkg.sv]
// Package: constants and carriers for the Manchester line codec
package mcodec_pkg;
  localparam int REF_MHZ         = 20;
  localparam int SYS_MHZ         = 100;
  localparam int REF_CYC         = SYS_MHZ / REF_MHZ;
  localparam int BIT_SUBS        = 4;
  localparam int IDLE_SEL_BIT    = 9;
  localparam int PRE_BITS        = 4;
  localparam int CRS_OFF_QTRS    = 6;
  localparam int CRS_HOLD_QTRS   = 8;
  localparam int CLSN_HOLD_QTRS  = 6;
  localparam logic [15:0] MODE_RST = 16'h0000;

  typedef enum logic [2:0] {
    MCODEC_RX_IDLE  = 3'b000,
    MCODEC_RX_HUNT  = 3'b001,
    MCODEC_RX_HALT  = 3'b010,
    MCODEC_RX_LOCK  = 3'b011,
    MCODEC_RX_RUN   = 3'b100,
    MCODEC_RX_HOLD  = 3'b101
  } mcodec_rx_state_t;

  typedef struct packed {
    logic pos;
    logic neg;
  } mcodec_pair_t;

  typedef struct packed {
    logic clk;
    logic data;
    logic crs;
  } mcodec_rx_out_t;
endpackage

// [logic/mcodec_top.sv]
// Module: Manchester encoder and decoder core
`timescale 1ns/1ps
module mcodec_top #(
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic                sys_clk,
  input  wire logic                rst_n,
  input  wire logic [15:0]         mode_register,
  input  wire logic                tx_nrz_data_in,
  input  wire logic                tx_request,
  output logic                     tx_data_ready,
  output mcodec_pkg::mcodec_pair_t tx_out_pair,
  output logic                     tx_out_pair_oe,
  output logic                     standard_bit_clock,
  input  wire logic                encoded_input_pair,
  input  wire logic                rx_signal_valid,
  input  wire logic                collision_input_pair,
  output logic                     recovered_rx_clock,
  output logic                     recovered_rx_data,
  output logic                     rx_carrier_sense,
  output logic                     collision_indication
);
  initial begin
    if (FIFO_DEPTH < 2) $error("FIFO_DEPTH too small");
    if (mcodec_pkg::REF_CYC < 4 || mcodec_pkg::REF_CYC > 8) begin
      $error("REF_CYC out of range");
    end
  end

  typedef struct packed {
    logic [2:0]                    div;
    logic                          ref_clk;
    logic [1:0]                    ph;
    logic                          bclk;
    logic                          txd;
    logic                          txen;
    logic                          cell_bit;
    logic                          cell_act;
    mcodec_pkg::mcodec_pair_t      pair;
    logic                          oe;
    mcodec_pkg::mcodec_rx_state_t  rst;
    logic [1:0]                    rph;
    logic [2:0]                    nbits;
    logic                          din_d;
    logic                          samp;
    mcodec_pkg::mcodec_rx_out_t    rxo;
    logic [3:0]                    crs_cnt;
    logic [3:0]                    cl_cnt;
    logic                          cl_d;
    logic                          clsn;
  } mcodec_state_t;

  mcodec_state_t s_r;
  mcodec_state_t s_nxt;
  logic          q_tick;
  logic          f_out_valid;
  logic          f_out_data;
  logic          f_in_ready;
  logic          take_bit;

  function automatic logic [3:0] dec4(input logic [3:0] v);
    return (v == 4'h0) ? 4'h0 : v - 4'h1;
  endfunction

  // Two quarter ticks per reference period, spaced 2 and 3 clocks
  assign q_tick = (s_r.div == 3'(mcodec_pkg::REF_CYC - 1))
               || (s_r.div == 3'(mcodec_pkg::REF_CYC / 2 - 1));
  // Source of a new cell at each bit boundary
  assign take_bit = q_tick && (s_r.ph == 2'd3) && f_out_valid;

  mcodec_fifo #(
    .WIDTH (1),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .in_data   (s_r.txd),
    .in_valid  (s_r.txen && q_tick && s_r.ph == 2'd3),
    .in_ready  (f_in_ready),
    .out_data  (f_out_data),
    .out_valid (f_out_valid),
    .out_ready (take_bit)
  );

  always_comb begin
    s_nxt = s_r;
    s_nxt.div = (s_r.div == 3'(mcodec_pkg::REF_CYC - 1)) ? 3'd0
                                                        : s_r.div + 3'd1;
    if (q_tick) begin
      s_nxt.ph = s_r.ph + 2'd1;
      s_nxt.ref_clk = s_r.ph[0];
      s_nxt.bclk = !s_r.ph[1];
      if (s_r.ph == 2'd3) begin
        s_nxt.txd = tx_nrz_data_in;
        s_nxt.txen = tx_request;
        s_nxt.cell_act = f_out_valid;
        s_nxt.cell_bit = f_out_data;
      end
      if (s_nxt.cell_act) begin
        // First half complement, second half true
        s_nxt.pair.pos = s_nxt.ph[1] ? s_nxt.cell_bit
                                      : !s_nxt.cell_bit;
        s_nxt.pair.neg = !s_nxt.pair.pos;
        s_nxt.oe = 1'b1;
      end else begin
        s_nxt.pair.pos = mode_register[mcodec_pkg::IDLE_SEL_BIT];
        s_nxt.pair.neg = 1'b0;
        s_nxt.oe = mode_register[mcodec_pkg::IDLE_SEL_BIT];
      end
      s_nxt.din_d = encoded_input_pair;
      s_nxt.rph = s_r.rph + 2'd1;
      s_nxt.crs_cnt = dec4(s_r.crs_cnt);
      s_nxt.cl_cnt = dec4(s_r.cl_cnt);
      s_nxt.cl_d = collision_input_pair;
      if (collision_input_pair) begin
        s_nxt.clsn = 1'b1;
      end
      if (collision_input_pair && !s_r.cl_d) begin
        s_nxt.cl_cnt = 4'(mcodec_pkg::CLSN_HOLD_QTRS);
      end else if (s_r.cl_cnt == 4'd1) begin
        // Set wins: hold the count while the input is still high
        if (collision_input_pair) begin
          s_nxt.cl_cnt = 4'd1;
        end else begin
          s_nxt.clsn = 1'b0;
        end
      end
      case (s_r.rst)
        mcodec_pkg::MCODEC_RX_IDLE: begin
          s_nxt.rph = s_r.ph + 2'd1;
          s_nxt.rxo.data = 1'b1;
          s_nxt.rxo.clk = 1'b0;
          s_nxt.rxo.crs = 1'b0;
          if (rx_signal_valid) begin
            s_nxt.rst = mcodec_pkg::MCODEC_RX_HUNT;
            s_nxt.nbits = 3'd0;
          end
        end
        mcodec_pkg::MCODEC_RX_HUNT: begin
          // Falling centre edge marks the first zero
          if (s_r.din_d && !encoded_input_pair) begin
            s_nxt.rst = mcodec_pkg::MCODEC_RX_HALT;
          end else if (!rx_signal_valid) begin
            s_nxt.rst = mcodec_pkg::MCODEC_RX_IDLE;
          end
        end
        mcodec_pkg::MCODEC_RX_HALT: begin
          s_nxt.rph = s_r.rph;
          if (s_r.din_d && !encoded_input_pair) begin
            s_nxt.rph = 2'd2;
            s_nxt.rst = mcodec_pkg::MCODEC_RX_LOCK;
          end else if (!rx_signal_valid) begin
            s_nxt.rst = mcodec_pkg::MCODEC_RX_IDLE;
          end
        end
        mcodec_pkg::MCODEC_RX_LOCK: begin
          if (s_r.rph == 2'd0) begin
            s_nxt.rxo.crs = 1'b1;
            s_nxt.rxo.clk = 1'b1;
            s_nxt.samp = !encoded_input_pair;
            s_nxt.crs_cnt = 4'(mcodec_pkg::CRS_OFF_QTRS);
            s_nxt.rst = mcodec_pkg::MCODEC_RX_RUN;
          end
        end
        mcodec_pkg::MCODEC_RX_RUN: begin
          // Rises with the data update at the quarter point
          s_nxt.rxo.clk = (s_r.rph == 2'd0) || (s_r.rph == 2'd1);
          if (s_r.din_d && !encoded_input_pair) begin
            s_nxt.crs_cnt = 4'(mcodec_pkg::CRS_OFF_QTRS);
          end else if (!s_r.din_d && encoded_input_pair) begin
            s_nxt.crs_cnt = 4'(mcodec_pkg::CRS_OFF_QTRS);
          end
          if (s_r.rph == 2'd0) begin
            s_nxt.rxo.data = s_r.samp;
            s_nxt.samp = !encoded_input_pair;
          end
          if (s_r.crs_cnt == 4'd1) begin
            s_nxt.rxo.crs = 1'b0;
            s_nxt.rxo.clk = 1'b0;
            s_nxt.rxo.data = 1'b1;
            s_nxt.crs_cnt = 4'(mcodec_pkg::CRS_HOLD_QTRS);
            s_nxt.rst = mcodec_pkg::MCODEC_RX_HOLD;
          end
        end
        mcodec_pkg::MCODEC_RX_HOLD: begin
          if (s_r.crs_cnt == 4'd1) begin
            s_nxt.rst = mcodec_pkg::MCODEC_RX_IDLE;
          end
        end
        default: begin
          s_nxt.rst = mcodec_pkg::MCODEC_RX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.rxo.data <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  logic tdr_r;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tdr_r <= 1'b0;
    end else begin
      tdr_r <= f_in_ready;
    end
  end

  assign tx_data_ready        = tdr_r;
  assign tx_out_pair          = s_r.pair;
  assign tx_out_pair_oe       = s_r.oe;
  assign standard_bit_clock   = s_r.bclk;
  assign recovered_rx_clock   = s_r.rxo.clk;
  assign recovered_rx_data    = s_r.rxo.data;
  assign rx_carrier_sense     = s_r.rxo.crs;
  assign collision_indication = s_r.clsn;

  a_idle_data_high: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_r.rst == mcodec_pkg::MCODEC_RX_IDLE |-> recovered_rx_data)
    else $error("data not high in idle");
  a_idle_no_clock: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !rx_carrier_sense |-> !recovered_rx_clock)
    else $error("clock runs without carrier");
  a_start_on_valid: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(s_r.rst == mcodec_pkg::MCODEC_RX_HUNT) |-> $past(rx_signal_valid))
    else $error("hunt without valid carrier");
  a_cell_balance: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_r.cell_act |-> tx_out_pair.pos != tx_out_pair.neg)
    else $error("encoded pair not differential");
  a_idle_level: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !s_r.cell_act && $past(q_tick) |->
      tx_out_pair.pos == mode_register[mcodec_pkg::IDLE_SEL_BIT]
      || $changed(mode_register))
    else $error("idle level wrong");
  a_hold_blocks: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(rx_carrier_sense) |-> !rx_carrier_sense [*8])
    else $error("carrier back during hold-off");
  a_bclk_period: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(standard_bit_clock) |-> ##10 $rose(standard_bit_clock))
    else $error("bit clock period wrong");
  a_clsn_rise: assert property (@(posedge sys_clk) disable iff (!rst_n)
    collision_input_pair && q_tick |=> collision_indication)
    else $error("collision not flagged");
  a_idle_phase_lock: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $past(q_tick) && $past(s_r.rst) == mcodec_pkg::MCODEC_RX_IDLE |->
      s_r.rph == s_r.ph)
    else $error("idle receive phase not locked");
endmodule

// [sim/mcodec_mau_model.sv]
// Attachment unit model: Manchester frame source and collision line
`timescale 1ns/1ps
module mcodec_mau_model (
  input  wire logic        sys_clk,
  input  wire logic        go,
  input  wire logic        qual,
  input  wire logic [15:0] bits,
  input  wire logic        clsn_go,
  output logic             encoded_input_pair,
  output logic             rx_signal_valid,
  output logic             collision_input_pair,
  output logic             busy
);
  int cyc = 0;
  initial begin
    encoded_input_pair   = 1'b1;
    rx_signal_valid      = 1'b0;
    collision_input_pair = 1'b0;
    busy                 = 1'b0;
  end
  always @(posedge sys_clk) begin
    collision_input_pair <= clsn_go;
    if (go) begin
      busy <= 1'b1;
      cyc  <= 0;
    end else if (busy) begin
      cyc <= cyc + 1;
      if (cyc == 100) begin
        // Ten cells sent; line biased high once released
        busy               <= 1'b0;
        rx_signal_valid    <= 1'b0;
        encoded_input_pair <= 1'b1;
      end else begin
        rx_signal_valid    <= qual;
        // First half carries the inverse of the bit
        encoded_input_pair <= bits[cyc/10] ^ (cyc % 10 < 5);
      end
    end
  end
endmodule

// [sim/tb_top.sv]
// Self-checking bench for the Manchester line codec core
`timescale 1ns/1ps
module tb_top;
  localparam logic [8:0]  TX_WORD = 9'h0B4;
  localparam logic [15:0] RX_WORD = 16'h02D5;
  logic                     sys_clk;
  logic                     rst_n;
  logic [15:0]              mode_register;
  logic                     tx_nrz_data_in;
  logic                     tx_request;
  logic                     tx_data_ready;
  mcodec_pkg::mcodec_pair_t tx_out_pair;
  logic                     tx_out_pair_oe;
  logic                     standard_bit_clock;
  logic                     encoded_input_pair;
  logic                     rx_signal_valid;
  logic                     collision_input_pair;
  logic                     recovered_rx_clock;
  logic                     recovered_rx_data;
  logic                     rx_carrier_sense;
  logic                     collision_indication;
  logic                     go;
  logic                     qual;
  logic                     clsn_go;
  logic                     busy;
  int                       n_errors = 0;
  int                       cmp_count = 0;
  int                       cyc = 0;

  mcodec_top #(.FIFO_DEPTH(8)) u_mcodec_top (
    .sys_clk, .rst_n, .mode_register, .tx_nrz_data_in, .tx_request,
    .tx_data_ready, .tx_out_pair, .tx_out_pair_oe, .standard_bit_clock,
    .encoded_input_pair, .rx_signal_valid, .collision_input_pair,
    .recovered_rx_clock, .recovered_rx_data, .rx_carrier_sense,
    .collision_indication
  );
  mcodec_mau_model u_mcodec_mau_model (
    .sys_clk, .go, .qual, .bits(RX_WORD), .clsn_go, .encoded_input_pair,
    .rx_signal_valid, .collision_input_pair, .busy
  );

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic report_and_stop();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      n_errors++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic sbc_rise();
    do @(negedge sys_clk); while (standard_bit_clock !== 1'b0);
    do @(negedge sys_clk); while (standard_bit_clock !== 1'b1);
  endtask

  task automatic t_clock();
    int hi;
    int lo;
    hi = 0;
    lo = 0;
    sbc_rise();
    while (standard_bit_clock === 1'b1 && hi < 20) begin
      hi++;
      @(negedge sys_clk);
    end
    while (standard_bit_clock === 1'b0 && lo < 20) begin
      lo++;
      @(negedge sys_clk);
    end
    chk(hi, 5);
    chk(lo, 5);
  endtask

  task automatic t_tx(input logic sel);
    logic [7:0]   got;
    logic         bad;
    logic [79:0]  rec;
    bad = 1'b0;
    got = 8'h00;
    @(posedge sys_clk);
    mode_register <= {6'h00, sel, 9'h000};
    chk(tx_data_ready, 1'b1);
    fork
      for (int i = 0; i <= 8; i++) begin
        sbc_rise();
        @(posedge sys_clk);
        tx_request     <= (i < 8);
        tx_nrz_data_in <= TX_WORD[i];
      end
      if (!sel) begin
        do @(negedge sys_clk); while (tx_out_pair_oe !== 1'b1);
        for (int k = 0; k < 80; k++) begin
          rec[k] = tx_out_pair.pos;
          if (tx_out_pair.neg !== ~tx_out_pair.pos) bad = 1'b1;
          if (tx_out_pair_oe !== 1'b1) bad = 1'b1;
          @(negedge sys_clk);
        end
        chk(tx_out_pair_oe, 1'b0);
      end
    join
    for (int i = 0; i < 8 && !sel; i++) begin
      got[i] = rec[10*i+7];
      if (rec[10*i+2] !== ~rec[10*i+7]) bad = 1'b1;
    end
    if (!sel) chk(got, TX_WORD[7:0]);
    chk(bad, 1'b0);
    repeat (60) @(negedge sys_clk);
    chk({tx_out_pair_oe, tx_out_pair}, {sel, sel, 1'b0});
  endtask

  task automatic t_rx(input logic q);
    int         t;
    int         t1;
    int         nr;
    logic [5:0] got;
    logic       pc;
    logic       ps;
    t = 0;
    t1 = 0;
    nr = 0;
    got = 6'h00;
    pc = 1'b0;
    ps = 1'b0;
    chk({recovered_rx_clock, recovered_rx_data}, 2'b01);
    @(posedge sys_clk);
    qual <= q;
    go   <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    while (t < 260 && !(ps && rx_carrier_sense === 1'b0)) begin
      @(negedge sys_clk);
      t++;
      if (recovered_rx_clock === 1'b1 && !pc) begin
        if (nr == 0) t1 = t;
        else if (nr <= 6) got[nr-1] = recovered_rx_data;
        nr++;
      end
      pc = recovered_rx_clock;
      if (rx_carrier_sense === 1'b1) ps = 1'b1;
    end
    if (q) begin
      chk(t1 >= 42 && t1 <= 52, 1'b1);
      chk(got, 6'h2D);
      chk(t >= 107 && t <= 117, 1'b1);
    end else begin
      chk({ps, nr != 0}, 2'b00);
    end
    while (busy === 1'b1) @(negedge sys_clk);
    repeat (60) @(negedge sys_clk);
    chk({recovered_rx_clock, recovered_rx_data}, 2'b01);
  endtask

  task automatic t_clsn();
    int t;
    t = 0;
    @(posedge sys_clk);
    clsn_go <= 1'b1;
    repeat (6) @(posedge sys_clk);
    clsn_go <= 1'b0;
    @(negedge sys_clk);
    chk(collision_indication, 1'b1);
    while (collision_indication === 1'b1 && t < 100) begin
      @(negedge sys_clk);
      t++;
    end
    chk(t >= 8 && t <= 16, 1'b1);
  endtask

  initial begin
    rst_n          = 1'b0;
    mode_register  = 16'h0000;
    tx_nrz_data_in = 1'b0;
    tx_request     = 1'b0;
    go             = 1'b0;
    qual           = 1'b0;
    clsn_go        = 1'b0;
    repeat (16) @(posedge sys_clk);
    @(negedge sys_clk);
    chk({tx_out_pair, tx_out_pair_oe, standard_bit_clock, recovered_rx_clock,
         recovered_rx_data, rx_carrier_sense, collision_indication,
         tx_data_ready}, 16'h0008);
    @(posedge sys_clk);
    rst_n <= 1'b1;
    t_clock();
    t_tx(1'b0);
    t_tx(1'b1);
    t_rx(1'b0);
    t_rx(1'b1);
    t_clsn();
    report_and_stop();
  end
endmodule
